// ---- rtl/mcu_next_addr_defines.vh ----
// constants for the microprogram next-address unit
`ifndef MCU_NEXT_ADDR_DEFINES_VH
`define MCU_NEXT_ADDR_DEFINES_VH

`define MA_WIDTH 9
`define ROW_LSB 4
`define MA_RESET 9'h000

// register byte offsets on the bus
`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define REG_PRESET 8'h08
`define REG_STEPS 8'h0c

// control register fields
`define CTRL_RUN_BIT 0
`define CTRL_STEP_BIT 1
`define CTRL_RESET 2'h0

// status register fields
`define ST_ADDR_LSB 0
`define ST_CARRY_BIT 9
`define ST_ZERO_BIT 10
`define ST_FLATCH_BIT 11
`define ST_LATCH_LSB 12
`define ST_LATCH_EN_BIT 16
`define ST_ISE_BIT 17
`define ST_WIDTH 18

// AHB-Lite encodings
`define HTRANS_NONSEQ 2'h2
`define HTRANS_SEQ 2'h3
`define HSIZE_WORD 3'h2
`define HRESP_OKAY 1'h0

// address control codes, compared under a mask of significant bits; AC_ISE_CODE is compared whole
`define AC_MASK_2 7'h60
`define AC_MASK_3 7'h70
`define AC_MASK_4 7'h78
`define AC_MASK_5 7'h7c
`define AC_JUMP_SAME_COLUMN 7'h00
`define AC_JUMP_ROW_ZERO 7'h20
`define AC_JUMP_SAME_ROW 7'h30
`define AC_TEST_INPUT_LATCH 7'h40
`define AC_TEST_CARRY 7'h50
`define AC_TEST_ZERO 7'h58
`define AC_TEST_SECONDARY_LATCH 7'h60
`define AC_TEST_LEFT_LATCH_BITS 7'h68
`define AC_JUMP_COLUMN_LATCH_EN 7'h70
`define AC_TEST_PRIMARY_BUS 7'h78
`define AC_TEST_RIGHT_LATCH_BITS 7'h7c
`define AC_ISE_CODE 7'h2f

// flag input functions, flag control bits 1..0
`define SET_BOTH_FLAGS 2'h0
`define SET_ZERO_FLAG_ONLY 2'h1
`define SET_CARRY_FLAG_ONLY 2'h2
`define HOLD_BOTH_FLAGS 2'h3

// flag output functions, flag control bits 3..2 as {bit3, bit2}
`define FLAG_OUT_FORCE_LOW 2'h0
`define FLAG_OUT_ZERO 2'h1
`define FLAG_OUT_CARRY 2'h2
`define FLAG_OUT_FORCE_HIGH 2'h3

`endif

// ---- rtl/mcu_ahb_regs.v ----
// AHB-Lite register slave for the next-address unit
`timescale 1ns/10ps
`default_nettype none
`include "mcu_next_addr_defines.vh"

module mcu_ahb_regs (
	input wire core_clk_in,
	input wire sys_rst_in,
	input wire hsel_in,
	input wire [7:0] haddr_in,
	input wire [1:0] htrans_in,
	input wire hwrite_in,
	input wire [2:0] hsize_in,
	input wire [31:0] hwdata_in,
	input wire hready_in,
	input wire [`ST_WIDTH-1:0] status_in,
	input wire [31:0] steps_in,
	output reg hreadyout_out,
	output reg [31:0] hrdata_out,
	output reg hresp_out,
	output reg run_out,
	output reg step_out,
	output reg preset_out,
	output reg [`MA_WIDTH-1:0] preset_addr_out
);

	reg wr_pend_r;
	reg [7:0] wr_addr_r;
	wire addr_phase;

	// only whole-word transfers are decoded; other sizes are accepted and ignored
	assign addr_phase = hsel_in && hready_in && htrans_in[1] && (hsize_in == `HSIZE_WORD);

	always @(posedge core_clk_in) begin
		if (sys_rst_in) begin
			hreadyout_out <= 1'b0;
			hrdata_out <= 32'h00000000;
			hresp_out <= `HRESP_OKAY;
			wr_pend_r <= 1'b0;
			wr_addr_r <= 8'h00;
			run_out <= 1'b0;
			step_out <= 1'b0;
			preset_out <= 1'b0;
			preset_addr_out <= `MA_RESET;
		end else begin
			hreadyout_out <= 1'b1;
			hresp_out <= `HRESP_OKAY;
			step_out <= 1'b0;
			preset_out <= 1'b0;
			wr_pend_r <= addr_phase && hwrite_in;
			wr_addr_r <= haddr_in;
			if (addr_phase && !hwrite_in) begin
				case (haddr_in)
					`REG_CTRL: hrdata_out <= {31'h00000000, run_out};
					`REG_STATUS: hrdata_out <= {{(32-`ST_WIDTH){1'b0}}, status_in};
					`REG_STEPS: hrdata_out <= steps_in;
					default: hrdata_out <= 32'h00000000;
				endcase
			end
			if (wr_pend_r) begin
				case (wr_addr_r)
					`REG_CTRL: begin
						run_out <= hwdata_in[`CTRL_RUN_BIT];
						step_out <= hwdata_in[`CTRL_STEP_BIT];
					end
					`REG_PRESET: begin
						preset_out <= 1'b1;
						preset_addr_out <= hwdata_in[`MA_WIDTH-1:0];
					end
					default: begin
					end
				endcase
			end
		end
	end

endmodule // mcu_ahb_regs

`default_nettype wire

// ---- rtl/mcu_next_addr.v ----
// next-address and flag logic of a microprogram control unit
//
// Decided for this implementation: the placing of the registers and the AHB-Lite register port.
`timescale 1ns/10ps
`default_nettype none
`include "mcu_next_addr_defines.vh"

module mcu_next_addr (
	input wire core_clk_in,
	input wire sys_rst_in,
	input wire hsel_in,
	input wire [7:0] haddr_in,
	input wire [1:0] htrans_in,
	input wire hwrite_in,
	input wire [2:0] hsize_in,
	input wire [31:0] hwdata_in,
	input wire hready_in,
	output wire hreadyout_out,
	output wire [31:0] hrdata_out,
	output wire hresp_out,
	input wire [6:0] address_control_bits_in,
	input wire [3:0] flag_control_bits_in,
	input wire [3:0] primary_instruction_bus_n_in,
	input wire [3:0] secondary_instruction_bus_n_in,
	input wire flag_input_line_n_in,
	input wire address_load_in,
	input wire output_enable_in,
	input wire row_output_enable_in,
	output reg [`MA_WIDTH-1:0] microprogram_address_out,
	output reg row_oe_n_out,
	output reg column_oe_n_out,
	output reg [2:0] secondary_latch_out,
	output reg latch_oe_n_out,
	output reg flag_output_line_n_out,
	output reg flag_oe_n_out,
	output reg interrupt_strobe_enable_out
);

	reg [`MA_WIDTH-1:0] ma_r;
	reg [`MA_WIDTH-1:0] ma_nxt;
	reg carry_r;
	reg carry_nxt;
	reg zero_r;
	reg zero_nxt;
	reg flag_latch_r;
	reg [3:0] latch_r;
	reg [3:0] latch_nxt;
	reg latch_en_r;
	reg latch_en_nxt;
	reg ise_nxt;
	reg fo_nxt;
	reg [31:0] steps_r;
	wire run;
	wire step_req;
	wire preset;
	wire [`MA_WIDTH-1:0] preset_addr;
	wire step;
	wire [6:0] ac;
	wire flag_in;
	wire [3:0] px;
	wire [3:0] sx;
	wire [`ST_WIDTH-1:0] status;

	function is_code;
		input [6:0] code;
		input [6:0] mask;
		input [6:0] value;
		begin
			is_code = ((code & mask) == value);
		end
	endfunction

	assign ac = address_control_bits_in;
	assign flag_in = ~flag_input_line_n_in;
	assign px = ~primary_instruction_bus_n_in;
	assign sx = ~secondary_instruction_bus_n_in;
	// the unit advances one microcycle per enabled edge; software may free-run or single-step
	assign step = run | step_req;

	assign status = {interrupt_strobe_enable_out, latch_en_r, latch_r, flag_latch_r,
		zero_r, carry_r, ma_r};

	mcu_ahb_regs regs (
		.core_clk_in(core_clk_in),
		.sys_rst_in(sys_rst_in),
		.hsel_in(hsel_in),
		.haddr_in(haddr_in),
		.htrans_in(htrans_in),
		.hwrite_in(hwrite_in),
		.hsize_in(hsize_in),
		.hwdata_in(hwdata_in),
		.hready_in(hready_in),
		.status_in(status),
		.steps_in(steps_r),
		.hreadyout_out(hreadyout_out),
		.hrdata_out(hrdata_out),
		.hresp_out(hresp_out),
		.run_out(run),
		.step_out(step_req),
		.preset_out(preset),
		.preset_addr_out(preset_addr)
	);

	// next address selection
	always @* begin
		ma_nxt = ma_r;
		if (address_load_in) begin
			ma_nxt = {1'b0, sx, px};
		end else if (is_code(ac, `AC_MASK_2, `AC_JUMP_SAME_COLUMN)) begin
			ma_nxt = {ac[4:0], ma_r[3:0]};
		end else if (is_code(ac, `AC_MASK_3, `AC_JUMP_ROW_ZERO)) begin
			ma_nxt = {5'h00, ac[3:0]};
		end else if (is_code(ac, `AC_MASK_3, `AC_JUMP_SAME_ROW)) begin
			ma_nxt = {ma_r[8:4], ac[3:0]};
		end else if (is_code(ac, `AC_MASK_3, `AC_TEST_INPUT_LATCH)) begin
			ma_nxt = {ma_r[8], ac[3:0], ma_r[3], 2'b01, flag_in};
		end else if (is_code(ac, `AC_MASK_4, `AC_TEST_CARRY)) begin
			ma_nxt = {ma_r[8:7], ac[2:0], ma_r[3], 2'b01, carry_r};
		end else if (is_code(ac, `AC_MASK_4, `AC_TEST_ZERO)) begin
			ma_nxt = {ma_r[8:7], ac[2:0], ma_r[3], 2'b01, zero_r};
		end else if (is_code(ac, `AC_MASK_4, `AC_TEST_SECONDARY_LATCH)) begin
			ma_nxt = {ma_r[8:7], ac[2:0], latch_r};
		end else if (is_code(ac, `AC_MASK_4, `AC_TEST_LEFT_LATCH_BITS)) begin
			ma_nxt = {ma_r[8:7], ac[2:0], 2'b01, latch_r[3:2]};
		end else if (is_code(ac, `AC_MASK_4, `AC_JUMP_COLUMN_LATCH_EN)) begin
			ma_nxt = {ma_r[8:7], ac[2:0], ma_r[3:0]};
		end else if (is_code(ac, `AC_MASK_5, `AC_TEST_RIGHT_LATCH_BITS)) begin
			ma_nxt = {ma_r[8:7], 1'b1, ac[1:0], 2'b11, latch_r[1:0]};
		end else begin
			ma_nxt = {ma_r[8:6], ac[1:0], px};
		end
	end

	// side functions that the address load does not inhibit
	always @* begin
		latch_nxt = latch_r;
		latch_en_nxt = is_code(ac, `AC_MASK_4, `AC_JUMP_COLUMN_LATCH_EN);
		if (is_code(ac, `AC_MASK_5, `AC_TEST_PRIMARY_BUS)) begin
			latch_nxt = sx;
		end
		ise_nxt = (ac == `AC_ISE_CODE);
	end

	// flag input functions, applied even during an address load
	always @* begin
		carry_nxt = carry_r;
		zero_nxt = zero_r;
		case (flag_control_bits_in[1:0])
			`SET_BOTH_FLAGS: begin
				carry_nxt = flag_in;
				zero_nxt = flag_in;
			end
			`SET_ZERO_FLAG_ONLY: begin
				zero_nxt = flag_in;
			end
			`SET_CARRY_FLAG_ONLY: begin
				carry_nxt = flag_in;
			end
			`HOLD_BOTH_FLAGS: begin
			end
			default: begin
			end
		endcase
	end

	// in the carry and zero modes the flag output follows the stepped flags on a step edge, even one a preset overrides, and the stored flags otherwise
	always @* begin
		case (flag_control_bits_in[3:2])
			`FLAG_OUT_FORCE_LOW: fo_nxt = 1'b0;
			`FLAG_OUT_CARRY: fo_nxt = step ? carry_nxt : carry_r;
			`FLAG_OUT_ZERO: fo_nxt = step ? zero_nxt : zero_r;
			`FLAG_OUT_FORCE_HIGH: fo_nxt = 1'b1;
			default: fo_nxt = 1'b0;
		endcase
	end

	// core state; only a preset moves it between steps, so a stopped unit otherwise holds its address
	always @(posedge core_clk_in) begin
		if (sys_rst_in) begin
			ma_r <= `MA_RESET;
			carry_r <= 1'b0;
			zero_r <= 1'b0;
			flag_latch_r <= 1'b0;
			latch_r <= 4'h0;
			latch_en_r <= 1'b0;
			steps_r <= 32'h00000000;
		end else if (preset) begin
			ma_r <= preset_addr;
		end else if (step) begin
			ma_r <= ma_nxt;
			carry_r <= carry_nxt;
			zero_r <= zero_nxt;
			flag_latch_r <= flag_in;
			latch_r <= latch_nxt;
			latch_en_r <= latch_en_nxt;
			steps_r <= steps_r + 32'h00000001;
		end
	end

	// registered pins; the enables hide outputs without touching the stored state
	always @(posedge core_clk_in) begin
		if (sys_rst_in) begin
			microprogram_address_out <= `MA_RESET;
			row_oe_n_out <= 1'b1;
			column_oe_n_out <= 1'b1;
			secondary_latch_out <= 3'h0;
			latch_oe_n_out <= 1'b1;
			flag_output_line_n_out <= 1'b1;
			flag_oe_n_out <= 1'b1;
			interrupt_strobe_enable_out <= 1'b0;
		end else begin
			microprogram_address_out <= (preset) ? preset_addr : (step ? ma_nxt : ma_r);
			column_oe_n_out <= ~output_enable_in;
			row_oe_n_out <= ~(output_enable_in & row_output_enable_in);
			secondary_latch_out <= step ? latch_nxt[2:0] : latch_r[2:0];
			latch_oe_n_out <= ~(output_enable_in & (step ? latch_en_nxt : latch_en_r));
			flag_output_line_n_out <= ~fo_nxt;
			flag_oe_n_out <= ~output_enable_in;
			interrupt_strobe_enable_out <= ise_nxt;
		end
	end

endmodule // mcu_next_addr

`default_nettype wire

// ---- tb/mcu_next_addr_asserts.sv ----
// port checker for the next-address unit
`timescale 1ns/10ps
`default_nettype none
module mcu_next_addr_asserts (
	input wire logic core_clk_in,
	input wire logic sys_rst_in,
	input wire logic hsel_in,
	input wire logic [7:0] haddr_in,
	input wire logic [1:0] htrans_in,
	input wire logic hwrite_in,
	input wire logic hready_in,
	input wire logic hreadyout_out,
	input wire logic [31:0] hrdata_out,
	input wire logic hresp_out,
	input wire logic [6:0] address_control_bits_in,
	input wire logic output_enable_in,
	input wire logic row_output_enable_in,
	input wire logic [8:0] microprogram_address_out,
	input wire logic row_oe_n_out,
	input wire logic column_oe_n_out,
	input wire logic flag_oe_n_out,
	input wire logic interrupt_strobe_enable_out
);
	default clocking @(posedge core_clk_in); endclocking
	default disable iff (sys_rst_in);
	sequence unmapped_rd_s;
		hsel_in && hready_in && htrans_in == 2'h2 && !hwrite_in && haddr_in == 8'h10;
	endsequence
	sequence after_rst_s;
		!$past(sys_rst_in);
	endsequence
	bus_okay_a: assert property (hresp_out == 1'b0) else $error("response not okay");
	bus_ready_a: assert property (after_rst_s |-> hreadyout_out) else $error("ready low");
	unmapped_zero_a: assert property (unmapped_rd_s |=> hrdata_out == 32'h0)
		else $error("unmapped read not zero");
	reset_state_a: assert property ($fell(sys_rst_in) |-> microprogram_address_out == 9'h000
		&& !interrupt_strobe_enable_out && row_oe_n_out) else $error("bad reset state");
	strobe_code_a: assert property (after_rst_s |-> interrupt_strobe_enable_out ==
		($past(address_control_bits_in) == 7'h2f)) else $error("strobe mismatch");
	row_float_a: assert property (after_rst_s |-> row_oe_n_out ==
		!($past(output_enable_in) && $past(row_output_enable_in))) else $error("row enable");
	column_float_a: assert property (after_rst_s |->
		column_oe_n_out == !$past(output_enable_in)) else $error("column enable");
	flag_float_a: assert property (after_rst_s |->
		flag_oe_n_out == !$past(output_enable_in)) else $error("flag enable");
endmodule // mcu_next_addr_asserts
bind mcu_next_addr mcu_next_addr_asserts u_asserts (.core_clk_in, .sys_rst_in, .hsel_in,
	.haddr_in, .htrans_in, .hwrite_in, .hready_in, .hreadyout_out, .hrdata_out, .hresp_out,
	.address_control_bits_in, .output_enable_in, .row_output_enable_in,
	.microprogram_address_out, .row_oe_n_out, .column_oe_n_out, .flag_oe_n_out,
	.interrupt_strobe_enable_out);
`default_nettype wire

// ---- tb/microcode_rom.sv ----
// microprogram memory model feeding codes back to the unit
`timescale 1ns/10ps
`default_nettype none
module microcode_rom (
	input wire logic core_clk_in,
	input wire logic [8:0] addr_in,
	input wire logic row_oe_n_in,
	input wire logic column_oe_n_in,
	output logic [6:0] ac_out,
	output logic [3:0] fc_out
);
	logic [10:0] mem [0:511];
	logic [10:0] last_r = 11'h000;
	// a floating address selects nothing: show a word that changes each cycle
	assign {fc_out, ac_out} = (row_oe_n_in || column_oe_n_in) ? ~last_r : mem[addr_in];
	always @(posedge core_clk_in) begin
		last_r <= {fc_out, ac_out};
	end
	initial begin
		for (int i = 0; i < 512; i++) mem[i] = 11'h000;
	end
endmodule // microcode_rom
`default_nettype wire

// ---- tb/testbench.sv ----
// self-checking bench for the next-address unit
`timescale 1ns/10ps
`default_nettype none
module testbench;
	logic clk = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0, rdy, hresp;
	logic [7:0] haddr = 8'h00;
	logic [1:0] htrans = 2'h0;
	logic [31:0] hwdata = 32'h0, hrdata, st;
	logic [3:0] px_n = 4'hf, sx_n = 4'hf, pr = 4'h0, fc;
	logic fi_n = 1'b1, ld = 1'b0, oe = 1'b1, row_output_enable = 1'b1, c = 1'b0, z = 1'b0, x;
	logic [6:0] ac;
	logic [8:0] ma, e;
	logic [2:0] lat;
	logic row_oe_n, col_oe_n, lat_oe_n, fo_n, fo_oe_n, interrupt_strobe_enable;
	logic [6:0] jc [4] = '{7'h15, 7'h2a, 7'h36, 7'h75};
	logic [6:0] lc [3] = '{7'h63, 7'h6d, 7'h7e};
	logic [11:0] ft [4] = '{{4'h8, 7'h55, 1'b0}, {4'h5, 7'h5a, 1'b1}, {4'h2, 7'h4b, 1'b1},
		{4'hf, 7'h56, 1'b0}};
	int failures = 0, check_count = 0;
	mcu_next_addr u_mcu_next_addr (.core_clk_in(clk), .sys_rst_in(rst), .hsel_in(hsel),
		.haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2),
		.hwdata_in(hwdata), .hready_in(rdy), .hreadyout_out(rdy), .hrdata_out(hrdata),
		.hresp_out(hresp), .address_control_bits_in(ac), .flag_control_bits_in(fc),
		.primary_instruction_bus_n_in(px_n), .secondary_instruction_bus_n_in(sx_n),
		.flag_input_line_n_in(fi_n), .address_load_in(ld), .output_enable_in(oe),
		.row_output_enable_in(row_output_enable), .microprogram_address_out(ma), .row_oe_n_out(row_oe_n),
		.column_oe_n_out(col_oe_n), .secondary_latch_out(lat), .latch_oe_n_out(lat_oe_n),
		.flag_output_line_n_out(fo_n), .flag_oe_n_out(fo_oe_n),
		.interrupt_strobe_enable_out(interrupt_strobe_enable));
	microcode_rom u_microcode_rom (.core_clk_in(clk), .addr_in(ma), .row_oe_n_in(row_oe_n),
		.column_oe_n_in(col_oe_n), .ac_out(ac), .fc_out(fc));
	always #12.5 clk = ~clk;
	task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			failures++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task conclude;
		$display("checks %0d failures %0d", check_count, failures);
		if (failures == 0 && check_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'b1; htrans <= 2'h2; haddr <= a; hwrite <= w;
		@(posedge clk); while (rdy !== 1'b1) @(posedge clk);
		hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
		@(posedge clk); while (rdy !== 1'b1) @(posedge clk);
		st = hrdata;
	endtask
	function automatic logic [8:0] nxt(input logic [8:0] m, input logic [6:0] a);
		if (ld) return {1'b0, ~sx_n, ~px_n};
		casez (a)
			7'b00?????: return {a[4:0], m[3:0]};
			7'b010????: return {5'h00, a[3:0]};
			7'b011????: return {m[8:4], a[3:0]};
			7'b100????: return {m[8], a[3:0], m[3], 2'b01, ~fi_n};
			7'b1010???: return {m[8:7], a[2:0], m[3], 2'b01, c};
			7'b1011???: return {m[8:7], a[2:0], m[3], 2'b01, z};
			7'b1100???: return {m[8:7], a[2:0], pr};
			7'b1101???: return {m[8:7], a[2:0], 2'b01, pr[3:2]};
			7'b1110???: return {m[8:7], a[2:0], m[3:0]};
			7'b11110??: return {m[8:6], a[1:0], ~px_n};
			default: return {m[8:7], 1'b1, a[1:0], 2'b11, pr[1:0]};
		endcase
	endfunction
	// the word is placed at both ends of the step so codes stay put afterwards
	task micro(input logic [8:0] a, input logic [3:0] f, input logic [6:0] code);
		e = nxt(a, code);
		u_microcode_rom.mem[a] <= {f, code};
		u_microcode_rom.mem[e] <= {f, code};
		ahb(1'b1, 8'h08, a);
		ahb(1'b1, 8'h00, 32'h2);
		repeat (4) @(posedge clk);
		if (f[1:0] != 2'h1 && f[1:0] != 2'h3) c = ~fi_n;
		if (f[1:0] < 2'h2) z = ~fi_n;
		if (code[6:2] == 5'b11110) pr = ~sx_n;
		x = f[3] & (f[2] | c) | f[2] & z;
	endtask
	task t_reset;
		ahb(1'b0, 8'h04, 32'h0);
		check("status", st, 32'h0);
		ahb(1'b0, 8'h10, 32'h0);
		check("unmapped", st, 32'h0);
		$display("t_reset done");
	endtask
	task t_jumps;
		foreach (jc[i]) begin
			micro(9'h155, 4'hf, jc[i]);
			check("jump addr", ma, e);
		end
		check("latch enable", lat_oe_n, 1'b0);
		$display("t_jumps done");
	endtask
	task t_flags;
		foreach (ft[i]) begin
			fi_n <= ft[i][0];
			@(posedge clk);
			micro(9'h15d, ft[i][11:8], ft[i][7:1]);
			check("test addr", ma, e);
			ahb(1'b0, 8'h04, 32'h0);
			check("flags", {st[10], st[9]}, {z, c});
			check("flag out", fo_n, !x);
		end
		$display("t_flags done");
	endtask
	task t_latch;
		sx_n <= 4'ha; px_n <= 4'h5;
		@(posedge clk);
		micro(9'h0a3, 4'hf, 7'h79);
		check("bus addr", ma, e);
		ahb(1'b0, 8'h04, 32'h0);
		check("latch", st[15:12], pr);
		check("latch pins", lat, pr[2:0]);
		foreach (lc[i]) begin
			micro(9'h0a3, 4'hf, lc[i]);
			check("latch addr", ma, e);
		end
		$display("t_latch done");
	endtask
	task t_load;
		ld <= 1'b1; sx_n <= 4'h3; px_n <= 4'hc; fi_n <= 1'b0;
		@(posedge clk);
		micro(9'h1f0, 4'h0, 7'h7a);
		check("load addr", ma, e);
		ahb(1'b0, 8'h04, 32'h0);
		check("load latch", st[15:12], pr);
		check("load flags", {st[10], st[9]}, {z, c});
		ld <= 1'b0;
		@(posedge clk);
		micro(9'h1f0, 4'hf, 7'h2f);
		check("strobe addr", ma, e);
		check("strobe", interrupt_strobe_enable, 1'b1);
		micro(9'h1f0, 4'hf, 7'h2e);
		check("no strobe", interrupt_strobe_enable, 1'b0);
		$display("t_load done");
	endtask
	task t_enables;
		row_output_enable <= 1'b0;
		repeat (3) @(posedge clk);
		check("row float", {row_oe_n, col_oe_n}, 2'b10);
		ahb(1'b0, 8'h04, 32'h0);
		check("addr kept", st[8:0], e);
		row_output_enable <= 1'b1; oe <= 1'b0;
		repeat (3) @(posedge clk);
		check("all float", {row_oe_n, col_oe_n, fo_oe_n, lat_oe_n}, 4'hf);
		oe <= 1'b1;
		repeat (3) @(posedge clk);
		// the last step was not a latch-enable jump, so the latch pins stay released
		check("all driven", {row_oe_n, col_oe_n, fo_oe_n, lat_oe_n}, 4'h1);
		// free run for exactly two edges: fifteen single steps so far plus two
		ahb(1'b1, 8'h00, 32'h1);
		ahb(1'b1, 8'h00, 32'h0);
		ahb(1'b0, 8'h0c, 32'h0);
		check("free run steps", st, 32'h11);
		check("free run addr", ma, 9'h00e);
		$display("t_enables done");
	endtask
	initial begin
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		t_reset;
		t_jumps;
		t_flags;
		t_latch;
		t_load;
		t_enables;
		conclude;
	end
	initial begin
		#100000;
		failures++;
		$display("ERROR watchdog expired");
		conclude;
	end
endmodule // testbench
`default_nettype wire
